/* cdfd_pkg.sv */
package cdfd_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ        = 125000;
  localparam int QUAL_TIME_US   = 4000;
  localparam int QUAL_CYCLES    = QUAL_TIME_US * CLK_KHZ / 1000;
  localparam int TX_LIMIT_MS    = 1000;
  localparam int TX_LIMIT_CYC   = TX_LIMIT_MS * CLK_KHZ;
  localparam int WD_TIMEOUT_MS  = 1500;
  localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLK_KHZ;
  localparam int CNT_W          = 28;

  // ****************************************
  // Register map
  // ****************************************
  localparam int         ADDR_W          = 5;
  localparam logic [4:0] ADDR_CTRL       = 5'h00;
  localparam logic [4:0] ADDR_STATUS     = 5'h04;
  localparam logic [4:0] ADDR_INT_STATUS = 5'h08;
  localparam logic [4:0] ADDR_INT_CLEAR  = 5'h0C;
  localparam logic [4:0] ADDR_INT_ENABLE = 5'h10;
  localparam int         CTRL_CLAMP_BIT  = 0;
  localparam logic       CTRL_CLAMP_RST  = 1'h1;
  localparam int         ST_CD_BIT       = 0;
  localparam int         ST_TX_BIT       = 1;
  localparam int         ST_WD_BIT       = 2;
  localparam int         ST_STATE_LSB    = 3;
  localparam int         IRQ_W           = 4;
  localparam logic [3:0] INT_EN_RST      = 4'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CD_IDLE    = 2'b00,
    CD_QUALIFY = 2'b01,
    CD_PRESENT = 2'b10,
    CD_HOLD    = 2'b11
  } cd_state_t;

  typedef struct packed {
    logic wd_expired;
    logic tx_timeout;
    logic carrier_lost;
    logic carrier_gained;
  } irq_bits_t;
endpackage

/* carrier_detect_frame_detector.sv */
// Behaviour
// - Carrier-present goes low only after amplitude above threshold for qualify time.
// - Carrier-present stays low at least qualify time after signal drops.
// - With clamping on, receive data forced idle while amplitude below level; code clamps in receive mode only, passes demodulator data in transmit.
// - Transmit data held at 0 in receive mode disables clamping.
// - Unclamped receive data passes demodulator output unchanged, noise included.
// - Mode select input at 0 means transmit, at 1 receive.
// - Transmit held longer than one second reverts to receive.
// - No watchdog falling edge for 1.5 s drives reset output high.
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
module carrier_detect_frame_detector #(
  parameter int QUAL_CYCLES    = cdfd_pkg::QUAL_CYCLES,
  parameter int TX_LIMIT_CYC   = cdfd_pkg::TX_LIMIT_CYC,
  parameter int WD_TIMEOUT_CYC = cdfd_pkg::WD_TIMEOUT_CYC
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_carrier_above,
  input  wire logic                        i_demod_data,
  input  wire logic                        i_txd,
  input  wire logic                        i_rx_tx_sel,
  input  wire logic                        i_watchdog,
  output logic                             o_carrier_present_n,
  output logic                             o_rxd,
  output logic                             o_tx_mode,
  output logic                             o_reset_out,
  output logic                             o_irq,
  input  wire logic [cdfd_pkg::ADDR_W-1:0] i_address,
  input  wire logic                        i_read,
  input  wire logic                        i_write,
  input  wire logic [31:0]                 i_writedata,
  input  wire logic [3:0]                  i_byteenable,
  output logic [31:0]                      o_readdata,
  output logic                             o_waitrequest
);
  localparam int                     CW       = cdfd_pkg::CNT_W;
  localparam logic [CW-1:0]          QUAL_LAST = CW'(QUAL_CYCLES - 1);
  localparam logic [CW-1:0]          TX_LAST  = CW'(TX_LIMIT_CYC - 1);
  localparam logic [CW-1:0]          WD_LAST  = CW'(WD_TIMEOUT_CYC - 1);

  cdfd_pkg::cd_state_t               cd_state_r;
  cdfd_pkg::cd_state_t               cd_state_nxt;
  logic [CW-1:0]                     cd_cnt_r;
  logic [CW-1:0]                     tx_cnt_r;
  logic                              tx_timeout_r;
  logic                              tx_timeout_nxt;
  logic [CW-1:0]                     wd_cnt_r;
  logic                              wd_prev_r;
  logic                              wd_fall;
  logic                              clamp_en_r;
  logic                              clamp_active;
  logic                              rd_pend_r;
  logic                              wr_ok;
  cdfd_pkg::irq_bits_t               int_status_r;
  cdfd_pkg::irq_bits_t               int_enable_r;
  cdfd_pkg::irq_bits_t               events;
  cdfd_pkg::irq_bits_t               clear_bits;

  // ****************************************
  // Carrier qualification
  // ****************************************
  always_comb begin
    cd_state_nxt = cd_state_r;
    case (cd_state_r)
      cdfd_pkg::CD_IDLE: begin
        if (i_carrier_above) begin
          cd_state_nxt = cdfd_pkg::CD_QUALIFY;
        end
      end
      cdfd_pkg::CD_QUALIFY: begin
        if (!i_carrier_above) begin
          cd_state_nxt = cdfd_pkg::CD_IDLE;
        end else if (cd_cnt_r == QUAL_LAST) begin
          cd_state_nxt = cdfd_pkg::CD_PRESENT;
        end
      end
      cdfd_pkg::CD_PRESENT: begin
        if (!i_carrier_above) begin
          cd_state_nxt = cdfd_pkg::CD_HOLD;
        end
      end
      cdfd_pkg::CD_HOLD: begin
        if (i_carrier_above) begin
          cd_state_nxt = cdfd_pkg::CD_PRESENT;
        end else if (cd_cnt_r == QUAL_LAST) begin
          cd_state_nxt = cdfd_pkg::CD_IDLE;
        end
      end
      default: begin
        cd_state_nxt = cdfd_pkg::CD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cd_state_r <= cdfd_pkg::CD_IDLE;
    end else begin
      cd_state_r <= cd_state_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || cd_state_nxt != cd_state_r) begin
      cd_cnt_r <= '0;
    end else if (cd_cnt_r != QUAL_LAST) begin
      cd_cnt_r <= cd_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_carrier_present_n <= 1'h1;
    end else begin
      o_carrier_present_n <= !(cd_state_nxt == cdfd_pkg::CD_PRESENT || cd_state_nxt == cdfd_pkg::CD_HOLD);
    end
  end

  // ****************************************
  // Receive data clamping
  // ****************************************
  // Transmit data low unclamps
  assign clamp_active = clamp_en_r && !o_tx_mode && i_txd;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rxd <= 1'h1;
    end else if (clamp_active && !i_carrier_above) begin
      o_rxd <= 1'h1;
    end else begin
      o_rxd <= i_demod_data;
    end
  end

  // ****************************************
  // Mode select and transmit limit
  // ****************************************
  assign tx_timeout_nxt = !i_rx_tx_sel && (tx_timeout_r || tx_cnt_r == TX_LAST);

  always_ff @(posedge i_clk) begin
    if (i_rst || i_rx_tx_sel) begin
      tx_cnt_r <= '0;
    end else if (tx_cnt_r != TX_LAST) begin
      tx_cnt_r <= tx_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_timeout_r <= 1'h0;
    end else begin
      tx_timeout_r <= tx_timeout_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_mode <= 1'h0;
    end else begin
      o_tx_mode <= !i_rx_tx_sel && !tx_timeout_nxt;
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  assign wd_fall = wd_prev_r && !i_watchdog;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wd_prev_r <= 1'h0;
    end else begin
      wd_prev_r <= i_watchdog;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || wd_fall) begin
      wd_cnt_r <= '0;
    end else if (wd_cnt_r != WD_LAST) begin
      wd_cnt_r <= wd_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || wd_fall) begin
      o_reset_out <= 1'h0;
    end else if (wd_cnt_r == WD_LAST) begin
      o_reset_out <= 1'h1;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign events.carrier_gained = cd_state_r == cdfd_pkg::CD_QUALIFY && cd_state_nxt == cdfd_pkg::CD_PRESENT;
  assign events.carrier_lost   = cd_state_r == cdfd_pkg::CD_HOLD && cd_state_nxt == cdfd_pkg::CD_IDLE;
  assign events.tx_timeout     = tx_timeout_nxt && !tx_timeout_r;
  assign events.wd_expired     = !wd_fall && wd_cnt_r == WD_LAST && !o_reset_out;
  assign wr_ok                 = i_write && i_byteenable[0];
  assign clear_bits            = (wr_ok && i_address == cdfd_pkg::ADDR_INT_CLEAR) ?
                                 cdfd_pkg::irq_bits_t'(i_writedata[cdfd_pkg::IRQ_W-1:0]) : '0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      int_status_r <= '0;
    end else begin
      int_status_r <= (int_status_r & ~clear_bits) | events;
    end
  end

  assign o_irq = |(int_status_r & int_enable_r);

  // ****************************************
  // Register bus
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clamp_en_r   <= cdfd_pkg::CTRL_CLAMP_RST;
      int_enable_r <= cdfd_pkg::INT_EN_RST;
    end else if (wr_ok && i_address == cdfd_pkg::ADDR_CTRL) begin
      clamp_en_r <= i_writedata[cdfd_pkg::CTRL_CLAMP_BIT];
    end else if (wr_ok && i_address == cdfd_pkg::ADDR_INT_ENABLE) begin
      int_enable_r <= cdfd_pkg::irq_bits_t'(i_writedata[cdfd_pkg::IRQ_W-1:0]);
    end
  end

  assign o_waitrequest = i_read && !rd_pend_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_pend_r <= 1'h0;
    end else begin
      rd_pend_r <= i_read && !rd_pend_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_readdata <= '0;
    end else if (i_read && !rd_pend_r) begin
      o_readdata <= '0;
      case (i_address)
        cdfd_pkg::ADDR_CTRL: begin
          o_readdata[cdfd_pkg::CTRL_CLAMP_BIT] <= clamp_en_r;
        end
        cdfd_pkg::ADDR_STATUS: begin
          o_readdata[cdfd_pkg::ST_CD_BIT]                          <= !o_carrier_present_n;
          o_readdata[cdfd_pkg::ST_TX_BIT]                          <= o_tx_mode;
          o_readdata[cdfd_pkg::ST_WD_BIT]                          <= o_reset_out;
          o_readdata[cdfd_pkg::ST_STATE_LSB+1:cdfd_pkg::ST_STATE_LSB] <= cd_state_r;
        end
        cdfd_pkg::ADDR_INT_STATUS: begin
          o_readdata[cdfd_pkg::IRQ_W-1:0] <= int_status_r;
        end
        cdfd_pkg::ADDR_INT_ENABLE: begin
          o_readdata[cdfd_pkg::IRQ_W-1:0] <= int_enable_r;
        end
        default: begin
          o_readdata <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  int unsigned above_run_r;
  int unsigned below_run_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      above_run_r <= 0;
      below_run_r <= 0;
    end else begin
      above_run_r <= i_carrier_above ? above_run_r + 1 : 0;
      below_run_r <= i_carrier_above ? 0 : below_run_r + 1;
    end
  end

  a_cd_qualify_time: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_carrier_present_n) |-> above_run_r >= QUAL_CYCLES)
    else $error("Carrier present asserted before qualify time");
  a_cd_hold_time: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_carrier_present_n) |-> below_run_r >= QUAL_CYCLES)
    else $error("Carrier present released before hold time");
  a_clamp_idle_data: assert property (@(posedge i_clk) disable iff (i_rst)
    (clamp_en_r && !o_tx_mode && i_txd && !i_carrier_above) |=> o_rxd)
    else $error("Receive data not clamped idle");
  a_unclamp_pass: assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_tx_mode && !i_txd) |=> o_rxd == $past(i_demod_data))
    else $error("Receive data clamped with transmit data low");
  a_carrier_pass: assert property (@(posedge i_clk) disable iff (i_rst)
    i_carrier_above |=> o_rxd == $past(i_demod_data))
    else $error("Receive data altered above level");
  a_mode_receive: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rx_tx_sel |=> !o_tx_mode)
    else $error("Transmit mode while receive selected");
  a_mode_transmit: assert property (@(posedge i_clk) disable iff (i_rst)
    ($fell(i_rx_tx_sel) && !tx_timeout_r) |=> o_tx_mode)
    else $error("Transmit select not followed");
  a_tx_revert_limit: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_tx_mode && tx_cnt_r == TX_LAST) |=> !o_tx_mode)
    else $error("Transmit mode exceeded limit");
  a_wd_reset_out: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_reset_out) |-> $past(wd_cnt_r) == WD_LAST && !$past(wd_fall))
    else $error("Reset output without timeout");
  a_wd_edge_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    wd_fall |=> !o_reset_out [*2])
    else $error("Reset output not cleared by edge");

  c_carrier_found: cover property (@(posedge i_clk) disable iff (i_rst) $fell(o_carrier_present_n));
  c_carrier_gone: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_carrier_present_n));
  c_tx_revert: cover property (@(posedge i_clk) disable iff (i_rst) $rose(tx_timeout_r));
  c_wd_expire: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_reset_out));
endmodule

/* host_model.sv */
`timescale 1ns/10ps
// ****************************************
// Host side: watchdog clock and frame detector
// ****************************************
module host_model #(
  parameter int HALF = 70,
  parameter int PRE  = 8
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_run,
  input  wire logic i_rxd,
  output logic      o_watchdog,
  output logic      o_frame_rx,
  output logic      o_synced
);
  int cnt;
  int mark_cnt;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mark_cnt   <= 0;
      o_frame_rx <= 1'b0;
    end else if (!o_frame_rx) begin
      mark_cnt   <= i_rxd ? mark_cnt + 1 : 0;
      o_frame_rx <= i_rxd && mark_cnt >= PRE - 1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_synced <= 1'b0;
    end else if (o_frame_rx && !i_rxd) begin
      o_synced <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt        <= 0;
      o_watchdog <= 1'b1;
    end else if (i_run) begin
      if (cnt == HALF - 1) begin
        cnt        <= 0;
        o_watchdog <= !o_watchdog;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  localparam int Q  = 20;
  localparam int TX = 100;
  localparam int WD = 150;
  logic        clk, rst, above, demod, txd, sel, wd, run, rd, wr;
  logic        cd_n, rxd, txm, rsto, irq, wait_req, frx, syn;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  e;
  logic [3:0]  pin_q[$];
  logic [31:0] rd_q[$];
  int          err_total, checks_done;
  wire  [6:0]  obs = {syn, frx, irq, rsto, txm, rxd, cd_n};

  carrier_detect_frame_detector #(.QUAL_CYCLES(Q), .TX_LIMIT_CYC(TX), .WD_TIMEOUT_CYC(WD)) carrier_detect_frame_detector_inst (
    .i_clk(clk), .i_rst(rst), .i_carrier_above(above), .i_demod_data(demod), .i_txd(txd),
    .i_rx_tx_sel(sel), .i_watchdog(wd), .o_carrier_present_n(cd_n), .o_rxd(rxd), .o_tx_mode(txm),
    .o_reset_out(rsto), .o_irq(irq), .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
    .i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(wait_req));
  host_model host_model_inst (.i_clk(clk), .i_rst(rst), .i_run(run), .i_rxd(rxd), .o_watchdog(wd),
    .o_frame_rx(frx), .o_synced(syn));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [2:0] s, input logic v);
    pin_q.push_back({s, v});
  endtask

  always @(negedge clk) begin
    while (pin_q.size() > 0) begin
      e = pin_q.pop_front();
      check({31'h0, obs[e[3:1]]}, {31'h0, e[0]});
    end
  end

  always @(posedge clk) begin
    if (rd && !wait_req && rd_q.size() > 0) check(rdata, rd_q.pop_front());
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Bus and stimulus tasks
  // ****************************************
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= we;
    rd    <= !we;
    do @(posedge clk); while (wait_req !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rdx(input logic [4:0] a, input logic [31:0] x);
    rd_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic rx_run(input logic clamped);
    logic d, dp;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      d = 1'($urandom);
      demod <= d;
      if (i > 1) note(3'd1, clamped ? 1'b1 : dp);
      dp = d;
    end
  endtask

  task automatic hold(input logic [2:0] s, input logic v, input int n);
    repeat (n) @(posedge clk);
    note(s, v);
  endtask

  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  initial begin
    {rst, above, demod, txd, sel, run, rd, wr, addr, wdata} = '0;
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    run = 1'b1;
    sel = 1'b1;
    txd = 1'b1;
    void'($urandom(75));
    repeat (16) @(posedge clk);
    for (int s = 0; s < 5; s++) note(3'(s), s != 0 && s != 1 ? 1'b0 : 1'b1);
    rst <= 1'b0;
    rdx(5'h00, 32'h1);
    rdx(5'h10, 32'h0);
    rdx(5'h08, 32'h0);
    rdx(5'h14, 32'h0);
    bus(1'b1, 5'h04, 32'hFF);
    rdx(5'h04, 32'h0);
    $display("end of test reset");
    bus(1'b1, 5'h10, 32'h3);
    @(posedge clk);
    above <= 1'b1;
    repeat (Q / 2) @(posedge clk);
    above <= 1'b0;
    @(posedge clk);
    above <= 1'b1;
    hold(3'd0, 1'b1, Q - 1);
    hold(3'd0, 1'b0, 4);
    note(3'd4, 1'b1);
    rdx(5'h08, 32'h1);
    rdx(5'h04, 32'h11);
    bus(1'b1, 5'h0C, 32'h1);
    note(3'd4, 1'b0);
    above <= 1'b0;
    hold(3'd0, 1'b0, Q - 1);
    hold(3'd0, 1'b1, 4);
    note(3'd4, 1'b1);
    bus(1'b1, 5'h10, 32'h0);
    note(3'd4, 1'b0);
    rdx(5'h08, 32'h2);
    bus(1'b1, 5'h0C, 32'hF);
    $display("end of test carrier");
    rx_run(1'b1);
    note(3'd5, 1'b1);
    txd <= 1'b0;
    rx_run(1'b0);
    txd <= 1'b1;
    bus(1'b1, 5'h00, 32'h0);
    rx_run(1'b0);
    note(3'd6, 1'b1);
    bus(1'b1, 5'h00, 32'h1);
    $display("end of test clamp");
    bus(1'b1, 5'h10, 32'hC);
    note(3'd0, 1'b1);
    sel <= 1'b0;
    hold(3'd2, 1'b1, 3);
    hold(3'd2, 1'b1, TX - 10);
    hold(3'd2, 1'b0, 12);
    note(3'd4, 1'b1);
    sel <= 1'b1;
    rdx(5'h08, 32'h4);
    bus(1'b1, 5'h0C, 32'h4);
    $display("end of test mode");
    run <= 1'b0;
    hold(3'd3, 1'b0, 5);
    hold(3'd3, 1'b1, WD + 5);
    note(3'd4, 1'b1);
    rdx(5'h04, 32'h4);
    rdx(5'h08, 32'h8);
    run <= 1'b1;
    hold(3'd3, 1'b0, WD);
    bus(1'b1, 5'h0C, 32'h8);
    note(3'd4, 1'b0);
    hold(3'd3, 1'b0, 3 * WD);
    $display("end of test watchdog");
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule
